// *** rtl/scdr_pkg.sv ***
package scdr_pkg;

  // ==========================================================================
  // register bus geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 32;
  localparam int unsigned NUM_REGS = 10;

  // ==========================================================================
  // register offsets
  localparam logic [6:0] OFS_RES_A    = 7'h3d;
  localparam logic [6:0] OFS_RES_B    = 7'h3e;
  localparam logic [6:0] OFS_RES_C    = 7'h3f;
  localparam logic [6:0] OFS_RES_D    = 7'h40;
  localparam logic [6:0] OFS_RES_E    = 7'h41;
  localparam logic [6:0] OFS_RES_F    = 7'h42;
  localparam logic [6:0] OFS_RES_G    = 7'h43;
  localparam logic [6:0] OFS_RES_H    = 7'h44;
  localparam logic [6:0] OFS_CNT_HIGH = 7'h45;
  localparam logic [6:0] OFS_CNT_LOW  = 7'h46;
  localparam logic [6:0] OFS_FIRST    = OFS_RES_A;
  localparam logic [6:0] OFS_LAST     = OFS_CNT_LOW;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_RES_A    = 16'h00a8;
  localparam logic [15:0] RST_RES_B    = 16'h00ae;
  localparam logic [15:0] RST_RES_C    = 16'h0000;
  localparam logic [15:0] RST_RES_D    = 16'h1388;
  localparam logic [15:0] RST_RES_E    = 16'h0000;
  localparam logic [15:0] RST_RES_F    = 16'h0140;
  localparam logic [15:0] RST_RES_G    = 16'h0000;
  localparam logic [15:0] RST_RES_H    = 16'h03e8;
  localparam logic [15:0] RST_CNT_HIGH = 16'h0000;
  localparam logic [15:0] RST_CNT_LOW  = 16'hc350;
  localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

  // reset values indexed by offset minus OFS_FIRST
  localparam logic [15:0] RST_TABLE [NUM_REGS] = '{
    RST_RES_A, RST_RES_B, RST_RES_C, RST_RES_D, RST_RES_E,
    RST_RES_F, RST_RES_G, RST_RES_H, RST_CNT_HIGH, RST_CNT_LOW
  };

  localparam int unsigned IDX_CNT_HIGH = 8;
  localparam int unsigned IDX_CNT_LOW  = 9;

  // ==========================================================================
  // divider
  localparam int unsigned DIV_SEL_W = 3;

  typedef enum logic [2:0] {
    SCDR_IDLE = 3'b001,
    SCDR_HOLD = 3'b010,
    SCDR_DONE = 3'b100
  } scdr_state_t;

endpackage

// *** rtl/scdr_regfile.sv ***
`timescale 1ns/1ps
module scdr_regfile
  import scdr_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  output logic      [CNT_W-1:0]  delay_count_out
);

  // ==========================================================================
  // storage
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic              hit;
  logic [ADDR_W-1:0] idx;

  assign hit = (addr_in >= OFS_FIRST) && (addr_in <= OFS_LAST);
  assign idx = addr_in - OFS_FIRST;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          regs[g] <= RST_TABLE[g]; // RULE9
        end else if (wr_in && hit && idx == ADDR_W'(g)) begin
          regs[g] <= wdata_in; // RULE15
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read path: data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_out <= RD_UNMAPPED;
    end else if (rd_in && hit) begin
      rdata_out <= regs[idx[3:0]]; // RULE15
    end else begin
      rdata_out <= RD_UNMAPPED;
    end
  end

  assign delay_count_out = {regs[IDX_CNT_HIGH], // RULE7
                            regs[IDX_CNT_LOW]}; // RULE8

endmodule // scdr_regfile

// *** rtl/scdr_smclk_div.sv ***
`timescale 1ns/1ps
module scdr_smclk_div
  import scdr_pkg::*;
#(
  parameter int unsigned DIV_W = 8
)
(
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic [DIV_SEL_W-1:0] div_sel_in,
  output logic                      tick_out
);

  // ==========================================================================
  // one tick every 2**div_sel core clocks; core clock stands in for the
  // oscillator, so the tick is an enable, not a derived clock
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] mask;

  assign mask = DIV_W'((1 << div_sel_in) - 1); // RULE13

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= (cnt + 1'b1) & mask;
      tick_out <= ((cnt & mask) == mask); // RULE13
    end
  end

endmodule // scdr_smclk_div

// *** rtl/scdr_top.sv ***
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// RULE1: host writes 0xa8 to offset 0x3d
// RULE2: host writes 0x322 to 0x3e, resets 0xae
// RULE3: host writes zero to 0x3f, 0x41, 0x43
// RULE4: host writes 0x1388 to offset 0x40
// RULE5: host writes 0x1f4 to 0x42, resets 0x140
// RULE6: host writes 0x3e8 to offset 0x44
// RULE7: offset 0x45 is delay count high half
// RULE8: offset 0x46 is delay count low half
// RULE9: low half resets to 0xc350
// RULE10: phase sync inserts delay of that count
// RULE11: host sets delay four times lock time
// RULE12: delay counts state machine clock periods
// RULE13: period is 2**divider over oscillator frequency
// RULE14: sync loads counter, holds modulator reset
// RULE15: registers read back last written value
module scdr_top
  import scdr_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic [ADDR_W-1:0]    addr_in,
  input  wire logic [DATA_W-1:0]    wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [DATA_W-1:0]    rdata_out,
  input  wire logic                 phase_sync_en_in,
  input  wire logic                 sync_pin_in,
  input  wire logic [DIV_SEL_W-1:0] cal_clk_div_in,
  output logic                      modulator_reset_out,
  output logic                      sync_busy_out
);

  // ==========================================================================
  // register bank
  logic [CNT_W-1:0] delay_count;

  scdr_regfile u_regs (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .wr_in           (wr_in),
    .rd_in           (rd_in),
    .rdata_out       (rdata_out),
    .delay_count_out (delay_count)
  );

  // ==========================================================================
  // state machine clock
  logic sm_tick;

  scdr_smclk_div u_div (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .div_sel_in  (cal_clk_div_in),
    .tick_out    (sm_tick)
  );

  // ==========================================================================
  // sync pin: two flops, then an edge detector on the second
  logic sync_meta;
  logic sync_s;
  logic sync_d;
  logic sync_event;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_meta <= 1'b0;
      sync_s    <= 1'b0;
      sync_d    <= 1'b0;
    end else begin
      sync_meta <= sync_pin_in;
      sync_s    <= sync_meta;
      sync_d    <= sync_s;
    end
  end

  assign sync_event = sync_s && !sync_d && phase_sync_en_in; // RULE10

  // ==========================================================================
  // delay sequencer
  scdr_state_t      state;
  scdr_state_t      next_state;
  logic [CNT_W-1:0] remain;

  always_comb begin
    next_state = state;
    case (state)
      SCDR_IDLE: begin
        if (sync_event) begin
          next_state = SCDR_HOLD; // RULE14
        end
      end
      SCDR_HOLD: begin
        // a zero count still costs one check before release
        if (remain == '0) begin
          next_state = SCDR_DONE;
        end
      end
      SCDR_DONE: begin
        next_state = SCDR_IDLE;
      end
      default: begin
        next_state = SCDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= SCDR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // the count is latched at the event so a rewrite mid-wait has no effect
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      remain <= '0;
    end else if (state == SCDR_IDLE && sync_event) begin
      remain <= delay_count; // RULE14
    end else if (state == SCDR_HOLD && sm_tick && remain != '0) begin
      remain <= remain - 1'b1; // RULE12
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      modulator_reset_out <= 1'b0;
      sync_busy_out       <= 1'b0;
    end else begin
      modulator_reset_out <= (next_state == SCDR_HOLD); // RULE14
      sync_busy_out       <= (next_state != SCDR_IDLE);
    end
  end

endmodule // scdr_top

// *** sim/scdr_top_monitor.sv ***
`timescale 1ns/1ps
module scdr_top_monitor
  import scdr_pkg::*;
(
  input wire logic [ADDR_W-1:0]    addr_in,
  input wire logic [DATA_W-1:0]    wdata_in,
  input wire logic [DATA_W-1:0]    rdata_out,
  input wire logic [DIV_SEL_W-1:0] cal_clk_div_in,
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic phase_sync_en_in,
  input wire logic sync_pin_in,
  input wire logic modulator_reset_out,
  input wire logic sync_busy_out
);
  // ==========================================================
  // delay count rebuilt from bus writes, and hold length
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] len;
  logic [63:0]      unit;
  logic [63:0]      span;
  assign unit = 64'h1 << cal_clk_div_in;
  assign span = {32'h0, cnt} << cal_clk_div_in;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) cnt <= {RST_CNT_HIGH, RST_CNT_LOW};
    else if (wr_in && addr_in == OFS_CNT_HIGH) cnt[31:16] <= wdata_in;
    else if (wr_in && addr_in == OFS_CNT_LOW) cnt[15:0] <= wdata_in;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !modulator_reset_out) len <= '0;
    else len <= len + 1'b1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_busy_tail;
    sync_busy_out ##1 !sync_busy_out;
  endsequence
  sequence s_event;
    $past(sync_pin_in, 2) &&
      ($past(phase_sync_en_in) || $past(phase_sync_en_in, 2));
  endsequence
  // ==========================================================
  // checks
  a_read_idle_zero: assert property (
    !$past(rd_in) |-> rdata_out == RD_UNMAPPED) else $error("rdata not idle");
  a_unmapped_read: assert property (
    $past(rd_in) && ($past(addr_in) < OFS_FIRST || $past(addr_in) > OFS_LAST)
    |-> rdata_out == RD_UNMAPPED) else $error("unmapped read not zero");
  a_count_high_read: assert property (
    $past(rd_in) && $past(addr_in) == OFS_CNT_HIGH
    |-> rdata_out == $past(cnt[31:16])) else $error("count high readback");
  a_count_low_read: assert property (
    $past(rd_in) && $past(addr_in) == OFS_CNT_LOW
    |-> rdata_out == $past(cnt[15:0])) else $error("count low readback");
  a_hold_span: assert property (
    $fell(modulator_reset_out) |-> (64'(len) + unit >= span) &&
    (64'(len) <= span + unit + 64'h4)) else $error("hold length off");
  a_start_needs_sync: assert property (
    $rose(modulator_reset_out) |-> s_event) else $error("hold without sync");
  a_start_from_idle: assert property (
    $rose(modulator_reset_out) |-> !$past(sync_busy_out))
    else $error("restart while busy");
  a_busy_covers_hold: assert property (
    modulator_reset_out |-> sync_busy_out) else $error("busy low in hold");
  a_busy_tail_one: assert property (
    $fell(modulator_reset_out) |-> s_busy_tail) else $error("busy tail");
endmodule // scdr_top_monitor

// *** sim/scdr_top_bench.sv ***
`timescale 1ns/1ps
module scdr_top_bench
  import scdr_pkg::*;
;
  logic [ADDR_W-1:0]    addr_in;
  logic [DATA_W-1:0]    wdata_in, rdata_out;
  logic [DIV_SEL_W-1:0] cal_clk_div_in;
  logic core_clk_in, rst_in, wr_in, rd_in, rd_q = 1'h0;
  logic phase_sync_en_in, sync_pin_in, modulator_reset_out, sync_busy_out;
  logic [15:0] m [NUM_REGS];
  logic [15:0] exp_q [$];
  logic [15:0] req [8] = '{16'h00a8, 16'h0322,
    16'h0000, 16'h1388, 16'h0000,
    16'h01f4, 16'h0000, 16'h03e8};
  int err_count, num_checks, i, nhi;
  logic [6:0]  addr_r;
  logic [15:0] data_r;
  bit [31:0] x = 32'h0001_5e9f;
  scdr_top u_dut (.core_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .phase_sync_en_in, .sync_pin_in, .cal_clk_div_in,
    .modulator_reset_out, .sync_busy_out);
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  function automatic bit [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // ==========================================================
  // bus cycle: notes the expected read data for the watcher
  task automatic op(bit w, bit r, logic [6:0] a, logic [15:0] d);
    bit hit;
    hit = a >= OFS_FIRST && a <= OFS_LAST;
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    if (w && hit) m[a - OFS_FIRST] = d;
    if (r) exp_q.push_back(hit ? m[a - OFS_FIRST] : RD_UNMAPPED);
    @(posedge core_clk_in);
  endtask
  task automatic chk_rd(logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_len(int n, int lo, int hi);
    num_checks++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("wrong value at %0t: hold %0d cycles", $time, n);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  always @(posedge core_clk_in) begin
    if (rd_q) chk_rd(exp_q.pop_front(), rdata_out);
    rd_q <= rd_in;
  end
  // ==========================================================
  // one sync event; pin pulses again while busy and must be ignored
  task automatic hold(logic [2:0] d, logic [31:0] c);
    int k, n, s;
    op(1, 0, OFS_CNT_HIGH, c[31:16]);
    op(1, 0, OFS_CNT_LOW, c[15:0]);
    cal_clk_div_in <= d;
    op(0, 0, 7'h00, 16'h0000);
    sync_pin_in <= 1'b1;
    for (k = 0; k < 40 && modulator_reset_out !== 1'b1; k++)
      @(negedge core_clk_in);
    if (k == 40) give_up();
    for (n = 0; n < 70000 && modulator_reset_out === 1'b1; n++) begin
      @(posedge core_clk_in);
      if (n < 4) sync_pin_in <= n[0];
      @(negedge core_clk_in);
    end
    if (n == 70000) give_up();
    s = int'(c) << d;
    chk_len(n, s - (1 << d) + 1, s + 1);
    @(posedge core_clk_in);
    sync_pin_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
  endtask
  initial begin
    {rst_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    rst_in = 1'b1;
    {phase_sync_en_in, sync_pin_in, cal_clk_div_in} = '0;
    for (i = 0; i < NUM_REGS; i++) m[i] = RST_TABLE[i];
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (i = 'h3b; i <= 'h48; i++) op(0, 1, i[6:0], 16'h0000);
    op(0, 1, 7'h7f, 16'h0000);
    for (i = 0; i < 8; i++) op(1, 0, OFS_FIRST + i[6:0], req[i]);
    repeat (200) begin
      x = rnd();
      addr_r = 7'h3b + 7'(x[19:16]);
      data_r = x[15:0];
      // reserved words only ever get their required values
      if (addr_r >= OFS_FIRST && addr_r < OFS_CNT_HIGH)
        data_r = req[addr_r - OFS_FIRST];
      op(x[20], !x[20], addr_r, data_r);
    end
    for (i = 'h3b; i <= 'h48; i++) op(0, 1, i[6:0], 16'h0000);
    phase_sync_en_in <= 1'b1;
    for (i = 0; i < 8; i++) hold(i[2:0], 32'h0000_0009);
    hold(3'h2, 32'h0000_0000);
    hold(3'h0, 32'h0001_0000);
    phase_sync_en_in <= 1'b0;
    sync_pin_in <= 1'b1;
    nhi = 0;
    for (i = 0; i < 12; i++) begin
      @(negedge core_clk_in);
      if ({modulator_reset_out, sync_busy_out} !== 2'h0) nhi++;
    end
    chk_len(nhi, 0, 0);
    report_and_stop();
  end
endmodule // scdr_top_bench
bind scdr_top scdr_top_monitor u_mon (.addr_in, .wdata_in, .rdata_out,
  .cal_clk_div_in, .core_clk_in, .rst_in, .wr_in, .rd_in, .phase_sync_en_in,
  .sync_pin_in, .modulator_reset_out, .sync_busy_out);
